// ==== common/alarm_relay_pkg.sv ====
// Constants, register map and types for the alarm to relay logic
package alarm_relay_pkg;
  localparam int NUM_ALARMS = 7;
  localparam int VAL_W = 16;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int TIMER_W = 16;
  localparam int EXT_W = 18;
  // Register map, word addresses
  localparam logic [ADDR_W-1:0] ALARM_STRIDE = 8'h08;
  localparam logic [2:0] OFS_HI_SP = 3'h0;
  localparam logic [2:0] OFS_LO_SP = 3'h1;
  localparam logic [2:0] OFS_HYS = 3'h2;
  localparam logic [2:0] OFS_TRIP = 3'h3;
  localparam logic [2:0] OFS_RESET = 3'h4;
  localparam logic [2:0] OFS_CFG = 3'h5;
  localparam logic [ADDR_W-1:0] RELAY_BASE = 8'h40;
  localparam logic [ADDR_W-1:0] ACK_CFG_ADDR = 8'h48;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h49;
  localparam logic [ADDR_W-1:0] ANN_ADDR = 8'h4A;
  // Alarm config fields
  localparam int SRC_LSB = 0;
  localparam int TRAIL_LSB = 2;
  localparam int LATCH_BIT = 5;
  localparam int HI_EN_BIT = 6;
  localparam int LO_EN_BIT = 7;
  localparam int ALLOC_LSB = 8;
  localparam int CFG_W = 15;
  // Relay config fields
  localparam int NC_BIT = 0;
  localparam int ACK_EN_BIT = 1;
  localparam int AND_BIT = 2;
  localparam int RCFG_W = 3;
  // Acknowledge source enables
  localparam int BTN2_EN_BIT = 0;
  localparam int REMOTE_EN_BIT = 1;
  // Reset values
  localparam logic [VAL_W-1:0] HYS_RESET = 16'h000A;
  localparam logic [VAL_W-1:0] SP_RESET = 16'h0000;
  localparam logic [TIMER_W-1:0] TIME_RESET = 16'h0000;
  localparam logic [CFG_W-1:0] CFG_RESET = 15'h0000;
  localparam logic [RCFG_W-1:0] RCFG_RESET = 3'h0;
  // Timing: delays count in tenths of a second
  localparam int CLK_FREQ_KHZ = 200_000;
  localparam int TICK_TIME_MS = 100;
  localparam int TICK_CYCLES = CLK_FREQ_KHZ * TICK_TIME_MS / 1000 * 1000;
  localparam logic [3:0] FLASH_PERIOD_TICKS = 4'hA;
  localparam logic [3:0] FLASH_ON_TICKS = 4'h5;
  localparam logic [3:0] SLOW_ON_TICKS = 4'h2;

  typedef enum logic [1:0] {
    SRC_CH1 = 2'b00,
    SRC_CH2 = 2'b01,
    SRC_TEMP1 = 2'b10,
    SRC_TEMP2 = 2'b11
  } src_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_TRIP = 3'b001,
    ST_ACTIVE = 3'b010,
    ST_RESET_WAIT = 3'b011,
    ST_HOLD = 3'b100
  } alarm_state_t;
endpackage

// ==== src/alarm_relay_logic.sv ====
// Alarm comparison, delay, latching and relay combining logic
//
// Function
// - Relays after the first use own setpoint or trail another's.
// - A relay may only trail a relay of lower index.
// - Trailing threshold is trailed setpoint plus own signed offset.
// - Positive offset puts threshold ahead, negative puts it behind.
// - High trails high setpoint, low trails low setpoint; both may coexist.
// - Trailing ignored when relays use different conductivity channels.
// - Each alarm compares one source: channel 1, 2, temperature 1 or 2.
// - Auto mode clears alarm once out of alarm, after hysteresis and delay.
// - Latching alarm stays until out of alarm and acknowledged, or reset.
// - Hysteresis, trip and reset delays also apply in latching mode.
// - Latching annunciator flashes when value enters alarm.
// - Leaving alarm unacknowledged switches to a longer-off flash.
// - Acknowledge makes annunciator steady; latch releases once out of alarm.
// - Per-relay contact sense: open when idle or closed when idle.
// - Optional relay acknowledge resets active alarm at once; default off.
// - Acknowledge from enter, optionally second button or remote input.
// - OR combining: relay active if any allocated alarm active; default.
// - AND combining: relay active only while all allocated alarms active.
// - High clears below setpoint less hysteresis; low above plus it.
// - Alarm asserts only after condition held for whole trip time.
// - Alarm holds for reset time after condition goes; restarts on return.
// - Each alarm has a per-relay allocation enable.
//
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/10ps
module alarm_relay_logic
  import alarm_relay_pkg::*;
#(
  parameter int NUM_ALARMS = alarm_relay_pkg::NUM_ALARMS,
  parameter int TICK_CYCLES = alarm_relay_pkg::TICK_CYCLES
) (
  input wire logic ref_clk, // System clock
  input wire logic resetn, // Asynchronous reset
  input wire logic [alarm_relay_pkg::ADDR_W-1:0] reg_addr, // Word address
  input wire logic [alarm_relay_pkg::DATA_W-1:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [alarm_relay_pkg::DATA_W-1:0] reg_rdata, // Read data
  input wire logic [alarm_relay_pkg::VAL_W-1:0] meas_ch1, // Channel 1
  input wire logic [alarm_relay_pkg::VAL_W-1:0] input_channel_two, // Ch 2
  input wire logic [alarm_relay_pkg::VAL_W-1:0] meas_temp1, // Temp 1
  input wire logic [alarm_relay_pkg::VAL_W-1:0] meas_temp2, // Temp 2
  input wire logic meas_update, // New values strobe
  input wire logic ack_enter_pin, // Enter button
  input wire logic ack_second_pin, // Second button
  input wire logic ack_remote_pin, // Remote input
  output logic [NUM_ALARMS-1:0] relay_contact, // 1 = contact closed
  output logic [NUM_ALARMS-1:0] annunciator // 1 = lamp lit
);
  import alarm_relay_pkg::*;

  localparam int TICK_W = $clog2(TICK_CYCLES + 1);

  if (NUM_ALARMS < 2 || NUM_ALARMS > 7) begin : g_bad_num
    $error("NUM_ALARMS must be 2 to 7");
  end
  if (TICK_CYCLES < 1) begin : g_bad_tick
    $error("TICK_CYCLES must be at least 1");
  end

  function automatic logic [ADDR_W-1:0] alarm_addr(input int a,
                                                    input logic [2:0] ofs);
    return ADDR_W'(a * ALARM_STRIDE) | ADDR_W'(ofs);
  endfunction

  function automatic logic signed [EXT_W-1:0] sx(input logic [VAL_W-1:0] v);
    return EXT_W'(signed'(v));
  endfunction

  // Settings
  logic [VAL_W-1:0] hi_sp_reg [NUM_ALARMS];
  logic [VAL_W-1:0] lo_sp_reg [NUM_ALARMS];
  logic [VAL_W-1:0] hys_reg [NUM_ALARMS];
  logic [TIMER_W-1:0] trip_reg [NUM_ALARMS];
  logic [TIMER_W-1:0] rst_time_reg [NUM_ALARMS];
  logic [CFG_W-1:0] cfg_reg [NUM_ALARMS];
  logic [RCFG_W-1:0] rcfg_reg [NUM_ALARMS];
  logic [1:0] ack_cfg_reg;

  integer k;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (k = 0; k < NUM_ALARMS; k++) begin
        hi_sp_reg[k] <= SP_RESET;
        lo_sp_reg[k] <= SP_RESET;
        hys_reg[k] <= HYS_RESET;
        trip_reg[k] <= TIME_RESET;
        rst_time_reg[k] <= TIME_RESET;
        cfg_reg[k] <= CFG_RESET;
        rcfg_reg[k] <= RCFG_RESET;
      end
      ack_cfg_reg <= 2'h0;
    end else if (reg_wr) begin
      for (k = 0; k < NUM_ALARMS; k++) begin
        if (reg_addr == alarm_addr(k, OFS_HI_SP)) begin
          hi_sp_reg[k] <= reg_wdata[VAL_W-1:0];
        end
        if (reg_addr == alarm_addr(k, OFS_LO_SP)) begin
          lo_sp_reg[k] <= reg_wdata[VAL_W-1:0];
        end
        if (reg_addr == alarm_addr(k, OFS_HYS)) begin
          hys_reg[k] <= reg_wdata[VAL_W-1:0];
        end
        if (reg_addr == alarm_addr(k, OFS_TRIP)) begin
          trip_reg[k] <= reg_wdata[TIMER_W-1:0];
        end
        if (reg_addr == alarm_addr(k, OFS_RESET)) begin
          rst_time_reg[k] <= reg_wdata[TIMER_W-1:0];
        end
        if (reg_addr == alarm_addr(k, OFS_CFG)) begin
          cfg_reg[k] <= reg_wdata[CFG_W-1:0];
        end
        if (reg_addr == RELAY_BASE + ADDR_W'(k)) begin
          rcfg_reg[k] <= reg_wdata[RCFG_W-1:0];
        end
      end
      if (reg_addr == ACK_CFG_ADDR) begin
        ack_cfg_reg <= reg_wdata[1:0];
      end
    end
  end

  // Tenth-second tick and flash phase
  logic [TICK_W-1:0] tick_cnt_reg;
  logic tick_reg;
  logic [3:0] phase_reg;
  wire tick_wrap = (tick_cnt_reg == TICK_W'(TICK_CYCLES - 1));

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tick_cnt_reg <= '0;
      tick_reg <= 1'b0;
      phase_reg <= 4'h0;
    end else begin
      tick_cnt_reg <= tick_wrap ? '0 : tick_cnt_reg + 1'b1;
      tick_reg <= tick_wrap;
      if (tick_reg) begin
        phase_reg <= (phase_reg == FLASH_PERIOD_TICKS - 4'h1) ? 4'h0 :
                     phase_reg + 4'h1;
      end
    end
  end

  wire flash_on = (phase_reg < FLASH_ON_TICKS);
  wire slow_on = (phase_reg < SLOW_ON_TICKS);

  // Acknowledge pins: three stages, change taken when stages 2 and 3 agree
  logic [2:0] ack_s1_reg, ack_s2_reg, ack_s3_reg, ack_lvl_reg, ack_edge_reg;
  wire [2:0] ack_pins = {ack_remote_pin, ack_second_pin, ack_enter_pin};
  wire [2:0] ack_agree = ~(ack_s2_reg ^ ack_s3_reg);
  wire [2:0] ack_lvl_next = (ack_agree & ack_s3_reg) |
                            (~ack_agree & ack_lvl_reg);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ack_s1_reg <= 3'h0;
      ack_s2_reg <= 3'h0;
      ack_s3_reg <= 3'h0;
      ack_lvl_reg <= 3'h0;
      ack_edge_reg <= 3'h0;
    end else begin
      ack_s1_reg <= ack_pins;
      ack_s2_reg <= ack_s1_reg;
      ack_s3_reg <= ack_s2_reg;
      ack_lvl_reg <= ack_lvl_next;
      ack_edge_reg <= ack_lvl_next & ~ack_lvl_reg;
    end
  end

  wire ack_pulse = ack_edge_reg[0] |
                   (ack_edge_reg[1] & ack_cfg_reg[BTN2_EN_BIT]) |
                   (ack_edge_reg[2] & ack_cfg_reg[REMOTE_EN_BIT]);

  wire [NUM_ALARMS-1:0] relay_ack_en;
  logic [NUM_ALARMS-1:0] alarm_vec;
  logic [NUM_ALARMS-1:0] ann_next;
  logic [NUM_ALARMS-1:0] cond_vec;

  genvar i, r;
  for (i = 0; i < NUM_ALARMS; i++) begin : g_alarm
    wire [1:0] src = cfg_reg[i][SRC_LSB +: 2];
    wire [2:0] tsel = cfg_reg[i][TRAIL_LSB +: 3];
    wire [2:0] tidx = tsel - 3'h1;
    wire [1:0] tsrc = cfg_reg[tidx][SRC_LSB +: 2];
    wire chan_clash = !src[1] && !tsrc[1] && (src != tsrc);
    wire trail_on = (i != 0) && (tsel != 3'h0) &&
                    (int'(tsel) <= i) && !chan_clash;
    wire signed [EXT_W-1:0] val =
      (src == SRC_CH1) ? sx(meas_ch1) :
      (src == SRC_CH2) ? sx(input_channel_two) :
      (src == SRC_TEMP1) ? sx(meas_temp1) : sx(meas_temp2);
    // Signed offset added to the like-kind setpoint of the trailed relay
    wire signed [EXT_W-1:0] thr_hi = trail_on ?
      sx(hi_sp_reg[tidx]) + sx(hi_sp_reg[i]) : sx(hi_sp_reg[i]);
    wire signed [EXT_W-1:0] thr_lo = trail_on ?
      sx(lo_sp_reg[tidx]) + sx(lo_sp_reg[i]) : sx(lo_sp_reg[i]);
    wire signed [EXT_W-1:0] hys = signed'({2'b00, hys_reg[i]});
    logic hi_c_reg, lo_c_reg;
    wire hi_next = cfg_reg[i][HI_EN_BIT] &&
      (hi_c_reg ? (val >= thr_hi - hys) : (val >= thr_hi));
    wire lo_next = cfg_reg[i][LO_EN_BIT] &&
      (lo_c_reg ? (val <= thr_lo + hys) : (val <= thr_lo));

    always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
        hi_c_reg <= 1'b0;
        lo_c_reg <= 1'b0;
      end else if (meas_update) begin
        hi_c_reg <= hi_next;
        lo_c_reg <= lo_next;
      end
    end

    wire cond = hi_c_reg | lo_c_reg;
    wire latch = cfg_reg[i][LATCH_BIT];
    // Acknowledge reset applies if any relay fed by this alarm allows it
    wire ack_clear = ack_pulse &&
      |(cfg_reg[i][ALLOC_LSB +: NUM_ALARMS] & relay_ack_en);
    alarm_state_t st_reg, st_next;
    logic [TIMER_W-1:0] tmr_reg, tmr_next;
    logic acked_reg, acked_next;
    wire active = (st_reg == ST_ACTIVE) || (st_reg == ST_RESET_WAIT);
    wire tmr_inc = tick_reg && (tmr_reg != {TIMER_W{1'b1}});

    always_comb begin
      st_next = st_reg;
      tmr_next = tmr_reg;
      case (st_reg)
        ST_IDLE: begin
          tmr_next = '0;
          if (cond) begin
            st_next = ST_TRIP;
          end
        end
        ST_TRIP: begin
          if (!cond) begin
            st_next = ST_IDLE;
            tmr_next = '0;
          end else if (tmr_reg >= trip_reg[i]) begin
            st_next = ST_ACTIVE;
            tmr_next = '0;
          end else if (tmr_inc) begin
            tmr_next = tmr_reg + 1'b1;
          end
        end
        ST_ACTIVE: begin
          tmr_next = '0;
          if (ack_clear) begin
            st_next = ST_HOLD;
          end else if (!cond) begin
            st_next = ST_RESET_WAIT;
          end
        end
        ST_RESET_WAIT: begin
          if (ack_clear) begin
            st_next = ST_HOLD;
          end else if (cond) begin
            st_next = ST_ACTIVE;
            tmr_next = '0;
          end else if (tmr_reg >= rst_time_reg[i]) begin
            if (!latch || acked_reg || ack_pulse) begin
              st_next = ST_IDLE;
            end
          end else if (tmr_inc) begin
            tmr_next = tmr_reg + 1'b1;
          end
        end
        ST_HOLD: begin
          // No re-trip until the condition has lapsed once
          tmr_next = '0;
          if (!cond) begin
            st_next = ST_IDLE;
          end
        end
        default: begin
          st_next = ST_IDLE;
          tmr_next = '0;
        end
      endcase
      // Clear applies on a fresh trip even with a press; set only while active
      if (ack_pulse && active) begin
        acked_next = 1'b1;
      end else if (st_reg == ST_TRIP && st_next == ST_ACTIVE) begin
        acked_next = 1'b0;
      end else begin
        acked_next = acked_reg;
      end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
        st_reg <= ST_IDLE;
        tmr_reg <= '0;
        acked_reg <= 1'b0;
      end else begin
        st_reg <= st_next;
        tmr_reg <= tmr_next;
        acked_reg <= acked_next;
      end
    end

    assign alarm_vec[i] = active;
    assign cond_vec[i] = cond;
    assign ann_next[i] = !active ? 1'b0 :
                         !latch ? 1'b1 :
                         acked_reg ? 1'b1 :
                         cond ? flash_on :
                         slow_on;
  end

  // Relay combining and contact sense
  logic [NUM_ALARMS-1:0] relay_next;
  for (r = 0; r < NUM_ALARMS; r++) begin : g_relay
    wire [NUM_ALARMS-1:0] col;
    for (i = 0; i < NUM_ALARMS; i++) begin : g_col
      assign col[i] = cfg_reg[i][ALLOC_LSB + r];
    end
    wire any_on = |(alarm_vec & col);
    wire all_on = (col != '0) && ((alarm_vec & col) == col);
    wire on = rcfg_reg[r][AND_BIT] ? all_on : any_on;
    assign relay_next[r] = on ^ rcfg_reg[r][NC_BIT];
    assign relay_ack_en[r] = rcfg_reg[r][ACK_EN_BIT];
  end

  // Register read
  logic [DATA_W-1:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    for (int a = 0; a < NUM_ALARMS; a++) begin
      if (reg_addr == alarm_addr(a, OFS_HI_SP)) begin
        rd_mux = DATA_W'(hi_sp_reg[a]);
      end
      if (reg_addr == alarm_addr(a, OFS_LO_SP)) begin
        rd_mux = DATA_W'(lo_sp_reg[a]);
      end
      if (reg_addr == alarm_addr(a, OFS_HYS)) begin
        rd_mux = DATA_W'(hys_reg[a]);
      end
      if (reg_addr == alarm_addr(a, OFS_TRIP)) begin
        rd_mux = DATA_W'(trip_reg[a]);
      end
      if (reg_addr == alarm_addr(a, OFS_RESET)) begin
        rd_mux = DATA_W'(rst_time_reg[a]);
      end
      if (reg_addr == alarm_addr(a, OFS_CFG)) begin
        rd_mux = DATA_W'(cfg_reg[a]);
      end
      if (reg_addr == RELAY_BASE + ADDR_W'(a)) begin
        rd_mux = DATA_W'(rcfg_reg[a]);
      end
    end
    if (reg_addr == ACK_CFG_ADDR) begin
      rd_mux = DATA_W'(ack_cfg_reg);
    end
    if (reg_addr == STATUS_ADDR) begin
      rd_mux = DATA_W'({cond_vec, relay_contact, alarm_vec});
    end
    if (reg_addr == ANN_ADDR) begin
      rd_mux = DATA_W'(annunciator);
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= '0;
      relay_contact <= '0;
      annunciator <= '0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : '0;
      relay_contact <= relay_next;
      annunciator <= ann_next;
    end
  end
endmodule // alarm_relay_logic

// ==== verif/alarm_relay_properties.sv ====
// Register port properties of the alarm relay logic
`timescale 1ns/10ps
module alarm_relay_properties
  import alarm_relay_pkg::*;
#(
  parameter int NUM_ALARMS = 7,
  parameter int TICK_CYCLES = 4
) (
  input wire logic ref_clk, // System clock
  input wire logic resetn, // Asynchronous reset
  input wire logic [alarm_relay_pkg::ADDR_W-1:0] reg_addr, // Address
  input wire logic reg_rd, // Read strobe
  input wire logic [alarm_relay_pkg::DATA_W-1:0] reg_rdata, // Read data
  input wire logic [NUM_ALARMS-1:0] relay_contact, // Contacts
  input wire logic [NUM_ALARMS-1:0] annunciator // Lamps
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  wire logic rd_stat = reg_rd && reg_addr == STATUS_ADDR;
  // Holes in the map: alarm offsets 6 and 7, relay slot 7, above lamps
  wire logic rd_hole = reg_rd && (reg_addr > ANN_ADDR || reg_addr == 8'h47
    || (reg_addr < RELAY_BASE && reg_addr[2:1] == 2'b11));
  property p_rdata_idle;
    !$past(reg_rd) |-> reg_rdata == '0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("data w/o read");
  property p_contact_status;
    rd_stat |=> reg_rdata[13:7] == $past(relay_contact);
  endproperty
  a_contact_status: assert property (p_contact_status)
    else $error("status");
  property p_status_top;
    rd_stat |=> reg_rdata[31:21] == 11'h000;
  endproperty
  a_status_top: assert property (p_status_top)
    else $error("status top");
  property p_ann_read;
    reg_rd && reg_addr == ANN_ADDR |=>
      reg_rdata[6:0] == $past(annunciator) && reg_rdata[31:7] == '0;
  endproperty
  a_ann_read: assert property (p_ann_read) else $error("lamp read");
  property p_hole;
    rd_hole |=> reg_rdata == '0;
  endproperty
  a_hole: assert property (p_hole) else $error("unmapped read");
  property p_cfg_width;
    reg_rd && reg_addr < RELAY_BASE && reg_addr[2:0] == OFS_CFG |=>
      reg_rdata[31:15] == '0;
  endproperty
  a_cfg_width: assert property (p_cfg_width) else $error("cfg width");
  property p_rcfg_width;
    reg_rd && reg_addr >= RELAY_BASE && reg_addr < 8'h47 |=>
      reg_rdata[31:3] == '0;
  endproperty
  a_rcfg_width: assert property (p_rcfg_width)
    else $error("relay cfg");
  property p_ack_width;
    reg_rd && reg_addr == ACK_CFG_ADDR |=> reg_rdata[31:2] == '0;
  endproperty
  a_ack_width: assert property (p_ack_width) else $error("ack cfg");
  c_status: cover property (rd_stat);
  c_contact: cover property ($rose(relay_contact[0]));
  c_lamp: cover property ($fell(annunciator[0]));
endmodule // alarm_relay_properties

bind alarm_relay_logic alarm_relay_properties #(
  .NUM_ALARMS(NUM_ALARMS), .TICK_CYCLES(TICK_CYCLES)
) chk_u (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .relay_contact(relay_contact),
  .annunciator(annunciator));

// ==== verif/ack_panel.sv ====
// Operator acknowledge panel model: two buttons and a remote input
`timescale 1ns/10ps
module ack_panel (
  input wire logic ref_clk, // System clock
  input wire logic [2:0] press_req, // One-cycle press per source
  output logic ack_enter_pin, // Enter button
  output logic ack_second_pin, // Second button
  output logic ack_remote_pin // Remote input
);
  // A press stays closed well past the input synchroniser
  logic [3:0] hold_reg [3];
  initial for (int i = 0; i < 3; i++) hold_reg[i] = 4'h0;
  always @(posedge ref_clk) begin
    for (int i = 0; i < 3; i++) begin
      if (press_req[i]) hold_reg[i] <= 4'hC;
      else if (hold_reg[i] != 4'h0) hold_reg[i] <= hold_reg[i] - 4'h1;
    end
  end
  assign ack_enter_pin = hold_reg[0] != 4'h0;
  assign ack_second_pin = hold_reg[1] != 4'h0;
  assign ack_remote_pin = hold_reg[2] != 4'h0;
endmodule // ack_panel

// ==== verif/alarm_relay_logic_tb_top.sv ====
// Self-checking testbench for the alarm relay logic
`timescale 1ns/10ps
module alarm_relay_logic_tb_top;
  import alarm_relay_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic [VAL_W-1:0] ch1 = '0;
  logic [VAL_W-1:0] ch2 = '0;
  logic [VAL_W-1:0] t1 = '0;
  logic [VAL_W-1:0] t2 = '0;
  logic meas_update = 1'b0;
  logic [2:0] press_req = '0;
  logic p_ent, p_sec, p_rem;
  logic [NUM_ALARMS-1:0] relay_contact, annunciator;
  int fails = 0;
  int comparisons = 0;
  always #2.5 ref_clk = ~ref_clk;
  // Short tick keeps delay and flash timing to a few cycles
  alarm_relay_logic #(.NUM_ALARMS(NUM_ALARMS), .TICK_CYCLES(4)) dut_u (
    .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .meas_ch1(ch1), .input_channel_two(ch2),
    .meas_temp1(t1), .meas_temp2(t2),
    .meas_update(meas_update), .ack_enter_pin(p_ent),
    .ack_second_pin(p_sec), .ack_remote_pin(p_rem),
    .relay_contact(relay_contact), .annunciator(annunciator));
  ack_panel panel_u (.ref_clk(ref_clk), .press_req(press_req),
    .ack_enter_pin(p_ent), .ack_second_pin(p_sec), .ack_remote_pin(p_rem));
  task automatic stop_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] e);
    comparisons++;
    if (got !== e) begin
      fails++;
      $display("mismatch at %0t got %0h expected %0h", $time, got, e);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task automatic meas(input logic [VAL_W-1:0] v1, input logic [VAL_W-1:0] v2);
    @(posedge ref_clk);
    ch1 <= v1;
    ch2 <= v2;
    meas_update <= 1'b1;
    @(posedge ref_clk);
    meas_update <= 1'b0;
    wt(8);
  endtask
  task automatic cchk(input logic [NUM_ALARMS-1:0] e);
    #1 chk(32'(relay_contact), 32'(e));
  endtask
  task automatic press(input int i);
    @(posedge ref_clk);
    press_req[i] <= 1'b1;
    @(posedge ref_clk);
    press_req[i] <= 1'b0;
    wt(24);
  endtask
  // Lamp-lit cycles over one full flash period of 40 cycles
  task automatic lamp(input int e);
    int n;
    n = 0;
    repeat (40) begin
      @(posedge ref_clk);
      #1 if (annunciator[0] === 1'b1) n++;
    end
    chk(32'(n), 32'(e));
  endtask
  initial begin
    #200us;
    fails++;
    stop_test();
  end
  initial begin
    wt(8);
    resetn <= 1'b1;
    rchk(8'h02, 32'h0000000A);
    rchk(8'h05, 32'h0);
    rchk(RELAY_BASE, 32'h0);
    rchk(8'h4B, 32'h0);
    $display("test reset values done");
    wr(8'h00, 32'd100);
    wr(8'h05, 32'h0140);
    meas(16'd100, 16'd0);
    cchk(7'h01);
    meas(16'd95, 16'd0);
    cchk(7'h01);
    meas(16'd89, 16'd0);
    cchk(7'h00);
    wr(RELAY_BASE, 32'h1);
    wt(4);
    cchk(7'h01);
    meas(16'd120, 16'd0);
    cchk(7'h00);
    wr(RELAY_BASE, 32'h0);
    $display("test auto alarm done");
    wr(8'h00, 32'd1000);
    wr(8'h08, 32'h0000FFCE);
    wr(8'h0D, 32'h0244);
    meas(16'd960, 16'd0);
    cchk(7'h02);
    meas(16'd939, 16'd0);
    cchk(7'h00);
    wr(8'h0D, 32'h0245);
    meas(16'd960, 16'd0);
    cchk(7'h02);
    $display("test trailing done");
    wr(8'h00, 32'd100);
    wr(8'h05, 32'h0440);
    wr(8'h08, 32'd200);
    wr(8'h0D, 32'h0440);
    meas(16'd150, 16'd0);
    cchk(7'h04);
    wr(RELAY_BASE + 8'h02, 32'h4);
    meas(16'd150, 16'd0);
    cchk(7'h00);
    meas(16'd250, 16'd0);
    cchk(7'h04);
    wr(8'h0D, 32'h0);
    $display("test combining done");
    wr(8'h05, 32'h0160);
    meas(16'd150, 16'd0);
    cchk(7'h01);
    lamp(20);
    meas(16'd0, 16'd0);
    cchk(7'h01);
    rchk(STATUS_ADDR, 32'h00000081);
    lamp(8);
    press(2);
    cchk(7'h01);
    wr(ACK_CFG_ADDR, 32'h2);
    press(2);
    cchk(7'h00);
    meas(16'd150, 16'd0);
    wr(ACK_CFG_ADDR, 32'h3);
    press(1);
    lamp(40);
    cchk(7'h01);
    rchk(ANN_ADDR, 32'h1);
    rchk(ACK_CFG_ADDR, 32'h3);
    meas(16'd0, 16'd0);
    cchk(7'h00);
    $display("test latching done");
    wr(8'h03, 32'h4);
    wr(8'h05, 32'h0140);
    meas(16'd150, 16'd0);
    cchk(7'h00);
    wt(20);
    cchk(7'h01);
    wr(RELAY_BASE, 32'h2);
    press(0);
    cchk(7'h00);
    $display("test trip and ack reset done");
    // Alarm 3 low on temp 1; alarm 4 trails its low setpoint on temp 2
    wr(8'h11, 32'd20);
    wr(8'h14, 32'h4);
    wr(8'h15, 32'h0882);
    wr(8'h19, 32'd5);
    wr(8'h1D, 32'h108F);
    @(posedge ref_clk);
    t1 <= 16'd22;
    t2 <= 16'd24;
    meas(16'd0, 16'd0);
    cchk(7'h10);
    @(posedge ref_clk);
    t1 <= 16'd18;
    meas(16'd0, 16'd0);
    cchk(7'h18);
    @(posedge ref_clk);
    t1 <= 16'd35;
    meas(16'd0, 16'd0);
    cchk(7'h18);
    wt(20);
    cchk(7'h10);
    // Trailing its own number is not allowed, so own offset stands alone
    wr(8'h1D, 32'h1093);
    @(posedge ref_clk);
    t2 <= 16'd18;
    meas(16'd0, 16'd0);
    cchk(7'h00);
    $display("test sources and reset delay done");
    stop_test();
  end
endmodule // alarm_relay_logic_tb_top
